// >>> logic/pha_alert.sv
`timescale 1ns/10ps
// Operation
// - discharge threshold is six bits, 512 mA per step, 0 to 32256 mA.
// - discharge event when measured discharge current exceeds the threshold.
// - discharge threshold resets to code 100000, 16384 mA.
// - discharge deglitch select: 1.6 ms, 100 us default, 6 ms, 12 ms.
// - with adapter present, only enabled sources drive alert; all zero disables.
// - adapter removed masks critical, nominal, battery and adapter sources.
// - enable bits 6..0 map comparator to adapter good; only bit 5 resets set.
// - battery source fires on rising edge, adapter source on falling edge.
// - every source triggering during one pulse sets its status bit.
// - status clears on first host read after alert returns high.
// - status clears when alert goes low to start a new pulse.
// - status bits 6..0 report their sources, one means triggered.
// - without extension, pulse holds low at least the selected minimum width.
// - with extension, alert stays low until host writes zero to clear bit.
// - system voltage source triggers after a fixed 20 us deglitch.
module pha_alert
	import pha_pkg::*;
#(
	parameter int DEG_100US_CYC = T_100US_NS / CLK_PERIOD_NS,
	parameter int DEG_1P6MS_CYC = T_1P6MS_NS / CLK_PERIOD_NS,
	parameter int DEG_6MS_CYC   = T_6MS_NS / CLK_PERIOD_NS,
	parameter int DEG_12MS_CYC  = T_12MS_NS / CLK_PERIOD_NS,
	parameter int SYSV_DEG_CYC  = T_20US_NS / CLK_PERIOD_NS,
	parameter int WID_100US_CYC = T_100US_NS / CLK_PERIOD_NS,
	parameter int WID_1MS_CYC   = T_1MS_NS / CLK_PERIOD_NS,
	parameter int WID_5MS_CYC   = T_5MS_NS / CLK_PERIOD_NS,
	parameter int WID_10MS_CYC  = T_10MS_NS / CLK_PERIOD_NS
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_cmd,
	input  wire logic [15:0] i_reg_wdata,
	output logic      [15:0] o_reg_rdata,
	output logic             o_reg_rvalid,
	input  wire logic [15:0] i_battery_discharge_current,
	input  wire logic        i_comparator_trip,
	input  wire logic        i_critical_input_current,
	input  wire logic        i_nominal_input_current,
	input  wire logic        i_system_voltage_low,
	input  wire logic        i_battery_present,
	input  wire logic        i_adapter_good,
	output logic             o_processor_hot_alert_n
);
	typedef enum logic {ST_IDLE, ST_ACTIVE} pha_state_type;

	// =============================================================
	// registers
	logic [5:0]     thr_q;
	logic [1:0]     deg_q;
	logic [6:0]     src_en_q;
	logic           ext_q;
	logic [1:0]     wid_q;
	logic           clr_q;
	logic [6:0]     status_q;
	logic           rd_armed_q;
	pha_state_type  state_q;
	logic [CNT_W-1:0] width_cnt_q;
	logic           dischg_over_q;
	logic           bat_prev_q;
	logic           adp_prev_q;

	logic           wr_opt0;
	logic           wr_opt1;
	logic           rd_status;
	logic           clr_write;
	logic [15:0]    thr_ma;
	logic [6:0]     src_eff;
	logic [CNT_W-1:0] deg_limit;
	logic [CNT_W-1:0] wid_limit;
	logic [4:0]     pins_sync;
	logic           dischg_lvl;
	logic           sysv_lvl;
	pha_src_type    raw;
	logic [6:0]     trig;
	logic           any_trig;

	assign wr_opt0   = i_reg_wr && (i_reg_cmd == ADDR_OPTION0);
	assign wr_opt1   = i_reg_wr && (i_reg_cmd == ADDR_OPTION1);
	assign rd_status = i_reg_rd && (i_reg_cmd == ADDR_STATUS);
	assign clr_write = wr_opt0 && !i_reg_wdata[CLR_BIT];

	// =============================================================
	// input conditioning
	pha_sync #(
		.WIDTH (5)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_async    ({i_comparator_trip, i_critical_input_current,
			i_nominal_input_current, i_system_voltage_low, i_battery_present}),
		.o_sync     (pins_sync)
	);

	// adapter good has a synchroniser stage pair of its own
	logic adp_sync;
	pha_sync #(
		.WIDTH (1)
	) u_sync_adp (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_async    (i_adapter_good),
		.o_sync     (adp_sync)
	);

	assign thr_ma = 16'(thr_q * THR_STEP_MA);

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			dischg_over_q <= 1'b0;
		end else begin
			dischg_over_q <= i_battery_discharge_current > thr_ma;
		end
	end

	always_comb begin
		unique case (deg_q)
			2'h0: deg_limit = CNT_W'(DEG_1P6MS_CYC);
			2'h1: deg_limit = CNT_W'(DEG_100US_CYC);
			2'h2: deg_limit = CNT_W'(DEG_6MS_CYC);
			2'h3: deg_limit = CNT_W'(DEG_12MS_CYC);
		endcase
	end

	pha_deglitch u_deg_dischg (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_raw      (dischg_over_q),
		.i_limit    (deg_limit),
		.o_level    (dischg_lvl)
	);

	pha_deglitch u_deg_sysv (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_raw      (pins_sync[1]),
		.i_limit    (CNT_W'(SYSV_DEG_CYC)),
		.o_level    (sysv_lvl)
	);

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			bat_prev_q <= 1'b0;
			adp_prev_q <= 1'b0;
		end else begin
			bat_prev_q <= pins_sync[0];
			adp_prev_q <= adp_sync;
		end
	end

	// =============================================================
	// source selection
	always_comb begin
		raw.cmp    = pins_sync[4];
		raw.crit   = pins_sync[3];
		raw.nom    = pins_sync[2];
		raw.dischg = dischg_lvl;
		raw.sysv   = sysv_lvl;
		raw.bat    = pins_sync[0] && !bat_prev_q;
		raw.adp    = adp_prev_q && !adp_sync;
	end

	// gating uses the previous adapter level so the removal edge itself still counts
	assign src_eff  = adp_prev_q ? src_en_q : (src_en_q & SRC_KEEP_NO_ADAPTER);
	assign trig     = raw & src_eff;
	assign any_trig = |trig;

	// =============================================================
	// register writes
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			thr_q    <= THR_RST;
			deg_q    <= DEG_RST;
			src_en_q <= SRC_RST;
		end else if (wr_opt1) begin
			thr_q    <= i_reg_wdata[THR_MSB:THR_LSB];
			deg_q    <= i_reg_wdata[DEG_MSB:DEG_LSB];
			src_en_q <= i_reg_wdata[SRC_MSB:0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ext_q <= EXT_RST;
			wid_q <= WID_RST;
		end else if (wr_opt0) begin
			ext_q <= i_reg_wdata[EXT_BIT];
			wid_q <= i_reg_wdata[WID_MSB:WID_LSB];
		end
	end

	// clear bit returns to idle once the pulse it released has ended
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			clr_q <= CLR_RST;
		end else if (wr_opt0) begin
			clr_q <= i_reg_wdata[CLR_BIT];
		end else if (state_q == ST_IDLE) begin
			clr_q <= CLR_RST;
		end
	end

	always_comb begin
		unique case (wid_q)
			2'h0: wid_limit = CNT_W'(WID_100US_CYC);
			2'h1: wid_limit = CNT_W'(WID_1MS_CYC);
			2'h2: wid_limit = CNT_W'(WID_10MS_CYC);
			2'h3: wid_limit = CNT_W'(WID_5MS_CYC);
		endcase
	end

	// =============================================================
	// pulse sequencing
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_q                 <= ST_IDLE;
			width_cnt_q             <= '0;
			o_processor_hot_alert_n <= 1'b1;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (any_trig) begin
						state_q                 <= ST_ACTIVE;
						width_cnt_q             <= CNT_W'(1);
						o_processor_hot_alert_n <= 1'b0;
					end
				end
				ST_ACTIVE: begin
					if (width_cnt_q < wid_limit) begin
						width_cnt_q <= width_cnt_q + CNT_W'(1);
					end
					if (ext_q ? clr_write : (width_cnt_q >= wid_limit && !any_trig)) begin
						state_q                 <= ST_IDLE;
						o_processor_hot_alert_n <= 1'b1;
					end
				end
			endcase
		end
	end

	// =============================================================
	// event status
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			status_q   <= '0;
			rd_armed_q <= 1'b0;
		end else if (state_q == ST_IDLE && any_trig) begin
			status_q   <= trig;
			rd_armed_q <= 1'b0;
		end else if (state_q == ST_ACTIVE) begin
			status_q   <= status_q | trig;
			rd_armed_q <= 1'b1;
		end else if (rd_status && rd_armed_q) begin
			status_q   <= '0;
			rd_armed_q <= 1'b0;
		end
	end

	// =============================================================
	// read data, one cycle after the strobe
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_reg_rdata  <= '0;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			unique case (i_reg_cmd)
				ADDR_STATUS:  o_reg_rdata <= {9'h000, status_q};
				ADDR_OPTION0: o_reg_rdata <= {10'h000, ext_q, wid_q, clr_q, 2'h0};
				ADDR_OPTION1: o_reg_rdata <= {thr_q, deg_q, 1'b0, src_en_q};
				default:      o_reg_rdata <= '0;
			endcase
		end
	end

	// =============================================================
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	logic [CNT_W-1:0] low_cnt_q;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || o_processor_hot_alert_n) begin
			low_cnt_q <= '0;
		end else begin
			low_cnt_q <= low_cnt_q + CNT_W'(1);
		end
	end

	chk_reset_values: assert property ($fell(i_sys_rst) |-> thr_q == 6'h20 && src_en_q == 7'h20)
		else $error("option register reset values wrong");
	chk_alert_cause: assert property ($fell(o_processor_hot_alert_n) |-> $past(any_trig))
		else $error("alert fell without an enabled source");
	chk_no_adapter: assert property (!adp_prev_q |-> (src_eff & 7'h33) == 7'h00)
		else $error("adapter sources not masked");
	chk_bat_oneshot: assert property (raw.bat |=> !raw.bat)
		else $error("battery source not one-shot");
	chk_status_accum: assert property (state_q == ST_ACTIVE |=> (status_q & $past(trig)) == $past(trig))
		else $error("triggered source not recorded");
	chk_rd_clear: assert property (rd_status && rd_armed_q && state_q == ST_IDLE && !any_trig
		|=> status_q == 7'h00)
		else $error("status not cleared by read");
	chk_start_clear: assert property (state_q == ST_IDLE && any_trig
		|=> status_q == $past(trig) && !o_processor_hot_alert_n)
		else $error("new pulse did not restart status");
	chk_min_width: assert property ($rose(o_processor_hot_alert_n) && !$past(ext_q)
		|-> $past(low_cnt_q) >= $past(wid_limit) - CNT_W'(1))
		else $error("alert pulse too short");
	chk_ext_hold: assert property (state_q == ST_ACTIVE && ext_q && !clr_write
		|=> !o_processor_hot_alert_n)
		else $error("extended pulse released early");

	cov_pulse: cover property ($fell(o_processor_hot_alert_n));
	cov_ext_release: cover property (ext_q && clr_write && state_q == ST_ACTIVE);
	cov_rd_clear: cover property (rd_status && rd_armed_q && status_q != 7'h00);
endmodule : pha_alert

// >>> include/pha_pkg.sv
// =============================================================
// alert profile constants and carriers
package pha_pkg;

	// =============================================================
	// register command codes
	localparam logic [7:0] ADDR_STATUS  = 8'h3a;
	localparam logic [7:0] ADDR_OPTION0 = 8'h3c;
	localparam logic [7:0] ADDR_OPTION1 = 8'h3d;

	// =============================================================
	// field positions
	localparam int THR_MSB = 15;
	localparam int THR_LSB = 10;
	localparam int DEG_MSB = 9;
	localparam int DEG_LSB = 8;
	localparam int SRC_MSB = 6;
	localparam int EXT_BIT = 5;
	localparam int WID_MSB = 4;
	localparam int WID_LSB = 3;
	localparam int CLR_BIT = 2;

	// =============================================================
	// reset values
	localparam logic [5:0]  THR_RST = 6'h20;
	localparam logic [1:0]  DEG_RST = 2'h1;
	localparam logic [6:0]  SRC_RST = 7'h20;
	localparam logic        EXT_RST = 1'h0;
	localparam logic [1:0]  WID_RST = 2'h2;
	localparam logic        CLR_RST = 1'h1;

	// discharge threshold step, milliamps per code
	localparam logic [15:0] THR_STEP_MA = 16'h0200;
	// sources that survive adapter removal: comparator, discharge, system voltage
	localparam logic [6:0]  SRC_KEEP_NO_ADAPTER = 7'h4c;

	// =============================================================
	// timing, in nanoseconds; cycle counts are derived in the top
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_100US_NS    = 100000;
	localparam int T_1MS_NS      = 1000000;
	localparam int T_1P6MS_NS    = 1600000;
	localparam int T_5MS_NS      = 5000000;
	localparam int T_6MS_NS      = 6000000;
	localparam int T_10MS_NS     = 10000000;
	localparam int T_12MS_NS     = 12000000;
	localparam int T_20US_NS     = 20000;
	localparam int CNT_W         = 22;

	typedef struct packed {
		logic cmp;
		logic crit;
		logic nom;
		logic dischg;
		logic sysv;
		logic bat;
		logic adp;
	} pha_src_type;

endpackage : pha_pkg

// >>> logic/pha_sync.sv
`timescale 1ns/10ps
// =============================================================
// two-stage synchroniser for asynchronous levels
module pha_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule : pha_sync

// >>> logic/pha_deglitch.sv
`timescale 1ns/10ps
// =============================================================
// level qualifier: output rises after input held high i_limit cycles
module pha_deglitch
	import pha_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_sys_rst,
	input  wire logic         i_raw,
	input  wire logic [W-1:0] i_limit,
	output logic              o_level
);
	logic [W-1:0] cnt_q;

	// any low sample restarts the qualification, so glitches never pass
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || !i_raw) begin
			cnt_q   <= '0;
			o_level <= 1'b0;
		end else if (cnt_q >= i_limit) begin
			o_level <= 1'b1;
		end else begin
			cnt_q <= cnt_q + W'(1);
		end
	end
endmodule : pha_deglitch

// >>> bench/pha_host_model.sv
`timescale 1ns/10ps
// =============================================================
// system host: decoded word writes and reads on the register strobes
module pha_host_model (
	input  wire logic        i_core_clk,
	input  wire logic [15:0] i_reg_rdata,
	input  wire logic        i_reg_rvalid,
	output logic             o_reg_wr,
	output logic             o_reg_rd,
	output logic [7:0]       o_reg_cmd,
	output logic [15:0]      o_reg_wdata
);
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_cmd = 8'h00;
		o_reg_wdata = 16'h0000;
	end

	task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
		@(negedge i_core_clk);
		o_reg_cmd = cmd;
		o_reg_wdata = data;
		o_reg_wr = 1'b1;
		@(negedge i_core_clk);
		o_reg_wr = 1'b0;
		// a released word must not linger as if still valid
		o_reg_wdata = ~data;
	endtask : wr

	task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
		int n;
		n = 0;
		data = 16'hdead;
		@(negedge i_core_clk);
		o_reg_cmd = cmd;
		o_reg_rd = 1'b1;
		@(negedge i_core_clk);
		o_reg_rd = 1'b0;
		while (i_reg_rvalid !== 1'b1 && n < 4) begin
			@(negedge i_core_clk);
			n++;
		end
		if (i_reg_rvalid === 1'b1) data = i_reg_rdata;
	endtask : rd
endmodule : pha_host_model

// >>> bench/pha_alert_tb.sv
`timescale 1ns/10ps
module pha_alert_tb;
	import pha_pkg::*;
	localparam int D100 = 6, D1P6 = 8, D6 = 10, D12 = 12, SV = 5;
	localparam int W100 = 8, W1M = 10, W5 = 14, W10 = 12;
	logic        clk, rst, wr, rd, rvalid, alert_n;
	logic [7:0]  cmd;
	logic [15:0] wdata, rdata, cur, d;
	pha_src_type srcs;
	int          failures, n_compared, cycles, lat, wid;
	int          wt [4] = '{W100, W1M, W10, W5};
	int          dg [4] = '{D1P6, D100, D6, D12};

	// =============================================================
	// clock, design and host
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	pha_alert #(.DEG_100US_CYC(D100), .DEG_1P6MS_CYC(D1P6), .DEG_6MS_CYC(D6),
		.DEG_12MS_CYC(D12), .SYSV_DEG_CYC(SV), .WID_100US_CYC(W100),
		.WID_1MS_CYC(W1M), .WID_5MS_CYC(W5), .WID_10MS_CYC(W10)) dut (
		.i_core_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_cmd(cmd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .i_battery_discharge_current(cur),
		.i_comparator_trip(srcs.cmp), .i_critical_input_current(srcs.crit),
		.i_nominal_input_current(srcs.nom), .i_system_voltage_low(srcs.sysv),
		.i_battery_present(srcs.bat), .i_adapter_good(srcs.adp),
		.o_processor_hot_alert_n(alert_n));

	pha_host_model host (.i_core_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
		.o_reg_wr(wr), .o_reg_rd(rd), .o_reg_cmd(cmd), .o_reg_wdata(wdata));

	// =============================================================
	// checking helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rng(input int v, input int lo, input int hi);
		n_compared++;
		if (v < lo || v > hi) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
		end
	endtask : rng

	task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
		host.rd(c, d);
		chk(d, exp);
	endtask : rdchk

	// toggles the chosen source pins, restores them after hold cycles,
	// and records when the alert fell and how long it stayed low
	task automatic fire(input pha_src_type s, input int hold);
		lat = -1;
		wid = 0;
		srcs = srcs ^ s;
		for (int i = 0; i < 120; i++) begin
			@(negedge clk);
			if (i == hold) srcs = srcs ^ s;
			// an unknown level counts as low so it cannot pass a no-pulse check
			if (alert_n !== 1'b1) begin
				wid++;
				if (lat < 0) lat = i;
			end
		end
	endtask : fire

	task automatic summarize();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	// a hang is cut short well beyond the few thousand cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end

	// =============================================================
	// test sequence
	initial begin
		failures = 0;
		n_compared = 0;
		cycles = 0;
		rst = 1'b1;
		cur = 16'h0000;
		srcs = 7'h01;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		rdchk(ADDR_OPTION1, 16'h8120);
		rdchk(ADDR_OPTION0, 16'h0014);
		rdchk(ADDR_STATUS, 16'h0000);
		rdchk(8'h00, 16'h0000);
		fire(7'h20, 2);
		rng(lat, 2, 6);
		rng(wid, W10, W10 + 5);
		rdchk(ADDR_STATUS, 16'h0020);
		rdchk(ADDR_STATUS, 16'h0000);
		for (int w = 0; w < 4; w++) begin
			host.wr(ADDR_OPTION0, {11'h000, 2'(w), 3'h4});
			fire(7'h20, 2);
			rng(wid, wt[w], wt[w] + 5);
		end
		host.wr(ADDR_OPTION1, 16'h8160);
		fire(7'h40, 2);
		rdchk(ADDR_STATUS, 16'h0040);
		host.wr(ADDR_OPTION1, 16'hffff);
		rdchk(ADDR_OPTION1, 16'hff7f);
		host.wr(ADDR_STATUS, 16'hffff);
		rdchk(ADDR_STATUS, 16'h0000);
		host.wr(ADDR_OPTION1, 16'h0000);
		fire(7'h77, 3);
		rng(wid, 0, 0);
		host.wr(ADDR_OPTION1, 16'h0408);
		cur = 16'd512;
		fire(7'h00, 0);
		rng(wid, 0, 0);
		for (int g = 0; g < 4; g++) begin
			host.wr(ADDR_OPTION1, {6'h01, 2'(g), 8'h08});
			cur = 16'd513;
			fire(7'h00, 0);
			rng(lat, dg[g], dg[g] + 7);
			cur = 16'h0000;
			repeat (30) @(negedge clk);
		end
		rdchk(ADDR_STATUS, 16'h0008);
		host.wr(ADDR_OPTION1, 16'h8132);
		srcs.adp = 1'b0;
		repeat (10) @(negedge clk);
		fire(7'h32, 3);
		rng(wid, 0, 0);
		host.wr(ADDR_OPTION1, 16'h8140);
		fire(7'h40, 2);
		rng(lat, 2, 6);
		srcs.adp = 1'b1;
		repeat (10) @(negedge clk);
		host.wr(ADDR_OPTION1, 16'h8102);
		fire(7'h02, 100);
		rng(wid, W5, W5 + 3);
		host.wr(ADDR_OPTION1, 16'h8101);
		fire(7'h01, 100);
		rng(wid, W5, W5 + 3);
		host.wr(ADDR_OPTION1, 16'h8144);
		fire(7'h04, SV - 2);
		rng(wid, 0, 0);
		fire(7'h44, 20);
		rdchk(ADDR_STATUS, 16'h0044);
		host.wr(ADDR_OPTION0, 16'h0024);
		fire(7'h40, 2);
		rng(wid, 110, 120);
		host.wr(ADDR_OPTION0, 16'h0020);
		repeat (2) @(negedge clk);
		chk({15'h0000, alert_n}, 16'h0001);
		summarize();
	end
endmodule : pha_alert_tb
